// [nsx_pkg.sv]
// Purpose: shared constants and types for the nibble swap / exchange / xor datapath
// Assumes: 8-bit core, one instruction issued per start pulse
// Notes: opcode values are the core's fixed encodings
package nsx_pkg;
  localparam logic [7:0] OPC_SWAP = 8'hc4;
  localparam logic [7:0] OPC_XCH_DIR = 8'hc5;
  localparam logic [6:0] OPC_XCH_IND = 7'h63;
  localparam logic [4:0] OPC_XCH_BANK = 5'h19;
  localparam logic [6:0] OPC_DIGIT_EXCHANGE_OP_IND = 7'h6b;
  localparam logic [4:0] OPC_XRL_BANK = 5'h0d;
  localparam logic [7:0] OPC_XRL_A_DIR = 8'h65;
  localparam logic [6:0] OPC_XRL_IND = 7'h33;
  localparam logic [7:0] OPC_XRL_A_IMM = 8'h64;
  localparam logic [7:0] OPC_XRL_DIR_A = 8'h62;
  localparam logic [7:0] OPC_XRL_DIR_IMM = 8'h63;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] SFR_BASE = 8'h80;

  typedef enum logic [3:0] {
    NSX_NONE, NSX_SWAP, NSX_XCH_BANK, NSX_XCH_DIR, NSX_XCH_IND, NSX_DIGIT_EXCHANGE_OP,
    NSX_XRL_BANK, NSX_XRL_A_DIR, NSX_XRL_IND, NSX_XRL_A_IMM, NSX_XRL_DIR_A, NSX_XRL_DIR_IMM
  } nsx_op_t;

  // one instruction as handed over by the decoder
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] operand;
    logic [7:0] operand2;
  } nsx_instr_t;

  // write-back request for the operand location
  typedef struct packed {
    logic we;
    logic [2:0] dest;
    logic [7:0] addr;
    logic [7:0] data;
  } nsx_wr_t;

  localparam logic [2:0] DEST_BANK = 3'h1;
  localparam logic [2:0] DEST_IRAM = 3'h2;
  localparam logic [2:0] DEST_DIR = 3'h3;
endpackage

// [nsx_decode.sv]
// Purpose: opcode classifier for the datapath
// Assumes: opcode byte is stable while start is high
// Notes: purely combinational
`timescale 1ns/1ns
module nsx_decode (
  input wire logic [7:0] opcode_in,
  output nsx_pkg::nsx_op_t op_out
);
  wire is_swap = (opcode_in == nsx_pkg::OPC_SWAP);
  wire is_xch_dir = (opcode_in == nsx_pkg::OPC_XCH_DIR);
  wire is_xch_bank = (opcode_in[7:3] == nsx_pkg::OPC_XCH_BANK);
  wire is_xch_ind = (opcode_in[7:1] == nsx_pkg::OPC_XCH_IND);
  wire is_digit_exchange_op = (opcode_in[7:1] == nsx_pkg::OPC_DIGIT_EXCHANGE_OP_IND);
  wire is_xrl_bank = (opcode_in[7:3] == nsx_pkg::OPC_XRL_BANK);
  wire is_xrl_a_dir = (opcode_in == nsx_pkg::OPC_XRL_A_DIR);
  wire is_xrl_ind = (opcode_in[7:1] == nsx_pkg::OPC_XRL_IND);
  wire is_xrl_a_imm = (opcode_in == nsx_pkg::OPC_XRL_A_IMM);
  wire is_xrl_dir_a = (opcode_in == nsx_pkg::OPC_XRL_DIR_A);
  wire is_xrl_dir_imm = (opcode_in == nsx_pkg::OPC_XRL_DIR_IMM);
  assign op_out = is_swap ? nsx_pkg::NSX_SWAP :
                  is_xch_dir ? nsx_pkg::NSX_XCH_DIR :
                  is_xch_bank ? nsx_pkg::NSX_XCH_BANK :
                  is_xch_ind ? nsx_pkg::NSX_XCH_IND :
                  is_digit_exchange_op ? nsx_pkg::NSX_DIGIT_EXCHANGE_OP :
                  is_xrl_bank ? nsx_pkg::NSX_XRL_BANK :
                  is_xrl_a_dir ? nsx_pkg::NSX_XRL_A_DIR :
                  is_xrl_ind ? nsx_pkg::NSX_XRL_IND :
                  is_xrl_a_imm ? nsx_pkg::NSX_XRL_A_IMM :
                  is_xrl_dir_a ? nsx_pkg::NSX_XRL_DIR_A :
                  is_xrl_dir_imm ? nsx_pkg::NSX_XRL_DIR_IMM : nsx_pkg::NSX_NONE;
endmodule

// [nsx_unit.sv]
// Purpose: execution datapath for nibble swap, byte/digit exchange and xor
// Assumes: operand read data (bank, iram, direct) is valid combinationally with start_in
// Notes: holds the accumulator; results appear one clock after start
// Overview of operation
// - swap exchanges accumulator nibbles, no flag change, one byte, one cycle
// - byte exchange loads accumulator from operand and writes old accumulator back
// - byte exchange operand is bank register, direct, or pointer-indirect, one cycle
// - digit exchange swaps low nibbles of accumulator and pointer-addressed ram byte
// - digit exchange keeps both high nibbles and all flags
// - xor writes bitwise exclusive or to destination, flags untouched
// - xor supports six operand combinations
// - xor into a port reads the output latch, not the pins; xor of a port into the accumulator reads dir_rd_in
// - direct xor inverts selected bits of any byte by immediate or accumulator mask
`timescale 1ns/1ns
module nsx_unit (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire nsx_pkg::nsx_instr_t instr_in,
  input wire logic [7:0] bank_rd_in,
  input wire logic [7:0] ptr_rd_in,
  input wire logic [7:0] iram_rd_in,
  input wire logic [7:0] dir_rd_in,
  input wire logic [7:0] dir_latch_in,
  output logic [2:0] bank_sel_out,
  output logic ptr_sel_out,
  output logic [7:0] acc_out,
  output nsx_pkg::nsx_wr_t wr_out,
  output logic done_out,
  output logic flags_we_out
);
  nsx_pkg::nsx_op_t op;
  logic [7:0] acc_q, acc_d;
  nsx_pkg::nsx_wr_t wr_q, wr_d;
  logic done_q;

  nsx_decode u_dec (
    .opcode_in(instr_in.opcode),
    .op_out(op)
  );

  // port addresses read the output latch so xor into a port never folds in pin levels; xor into the accumulator still reads dir_rd_in
  wire is_sfr = (instr_in.operand >= nsx_pkg::SFR_BASE);
  wire [7:0] dir_val = is_sfr ? dir_latch_in : dir_rd_in;
  wire [7:0] ind_addr = ptr_rd_in;
  wire [7:0] imm = instr_in.operand;

  // nibble rotate shared by the datapath and its check, so both read the same way
  function automatic logic [7:0] nib_swap(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction

  always_comb begin
    acc_d = acc_q;
    wr_d = '0;
    if (start_in) begin
      unique case (op)
        nsx_pkg::NSX_SWAP: acc_d = nib_swap(acc_q);
        nsx_pkg::NSX_XCH_BANK: begin
          acc_d = bank_rd_in;
          wr_d = '{1'b1, nsx_pkg::DEST_BANK, {5'h00, instr_in.opcode[2:0]}, acc_q};
        end
        nsx_pkg::NSX_XCH_DIR: begin
          acc_d = dir_rd_in;
          wr_d = '{1'b1, nsx_pkg::DEST_DIR, instr_in.operand, acc_q};
        end
        nsx_pkg::NSX_XCH_IND: begin
          acc_d = iram_rd_in;
          wr_d = '{1'b1, nsx_pkg::DEST_IRAM, ind_addr, acc_q};
        end
        nsx_pkg::NSX_DIGIT_EXCHANGE_OP: begin
          acc_d = {acc_q[7:4], iram_rd_in[3:0]};
          wr_d = '{1'b1, nsx_pkg::DEST_IRAM, ind_addr, {iram_rd_in[7:4], acc_q[3:0]}};
        end
        nsx_pkg::NSX_XRL_BANK: acc_d = acc_q ^ bank_rd_in;
        nsx_pkg::NSX_XRL_A_DIR: acc_d = acc_q ^ dir_rd_in;
        nsx_pkg::NSX_XRL_IND: acc_d = acc_q ^ iram_rd_in;
        nsx_pkg::NSX_XRL_A_IMM: acc_d = acc_q ^ imm;
        nsx_pkg::NSX_XRL_DIR_A: wr_d = '{1'b1, nsx_pkg::DEST_DIR, instr_in.operand, dir_val ^ acc_q};
        nsx_pkg::NSX_XRL_DIR_IMM: wr_d = '{1'b1, nsx_pkg::DEST_DIR, instr_in.operand,
                                           dir_val ^ instr_in.operand2};
        nsx_pkg::NSX_NONE: acc_d = acc_q;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      acc_q <= nsx_pkg::ACC_RST;
      wr_q <= '0;
      done_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      wr_q <= wr_d;
      done_q <= start_in && (op != nsx_pkg::NSX_NONE);
    end
  end

  assign bank_sel_out = instr_in.opcode[2:0];
  assign ptr_sel_out = instr_in.opcode[0];
  assign acc_out = acc_q;
  assign wr_out = wr_q;
  assign done_out = done_q;
  assign flags_we_out = 1'b0;

  logic [7:0] acc_p;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      acc_p <= 8'h00;
    end else begin
      acc_p <= acc_q;
    end
  end

  AST_SWAP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_SWAP |=> acc_q == nib_swap(acc_p))
    else $error("swap result wrong");
  AST_XCH_WB: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_XCH_IND |=> wr_q.we && wr_q.data == acc_p && wr_q.dest == nsx_pkg::DEST_IRAM)
    else $error("exchange write-back wrong");
  AST_XCH_BANK: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_XCH_BANK |=> acc_q == $past(bank_rd_in) && wr_q.dest == nsx_pkg::DEST_BANK)
    else $error("bank exchange wrong");
  AST_DIGIT_EXCHANGE_OP_LO: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_DIGIT_EXCHANGE_OP |=> acc_q[3:0] == $past(iram_rd_in[3:0]) && wr_q.data[3:0] == acc_p[3:0])
    else $error("digit exchange low nibble wrong");
  AST_DIGIT_EXCHANGE_OP_HI: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_DIGIT_EXCHANGE_OP |=> acc_q[7:4] == acc_p[7:4] && wr_q.data[7:4] == $past(iram_rd_in[7:4]))
    else $error("digit exchange high nibble changed");
  AST_NO_FLAGS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    done_q |-> !flags_we_out)
    else $error("flags written");
  AST_XRL_IMM: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_XRL_A_IMM |=> acc_q == (acc_p ^ $past(instr_in.operand)) && !wr_q.we)
    else $error("xor immediate wrong");
  AST_XRL_LATCH: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_XRL_DIR_A && is_sfr |=> wr_q.data == ($past(dir_latch_in) ^ acc_p))
    else $error("port xor did not use latch");
  AST_XRL_DIR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_XRL_DIR_IMM |=> wr_q.we && acc_q == acc_p && wr_q.addr == $past(instr_in.operand))
    else $error("direct xor wrong");
  AST_XCH_DIR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && instr_in.opcode == nsx_pkg::OPC_XCH_DIR |=> done_q && acc_q == $past(dir_rd_in) && wr_q.data == acc_p)
    else $error("direct exchange wrong");

  // every form checked under its own label so a decode slip points at one encoding
  AST_XCH_IND_ACC: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_XCH_IND |=> acc_q == $past(iram_rd_in) && wr_q.addr == $past(ptr_rd_in))
    else $error("indirect exchange wrong");

  AST_XCH_BANK_WB: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_XCH_BANK |=> wr_q.we && wr_q.data == acc_p
      && wr_q.addr == {5'h00, $past(instr_in.opcode[2:0])})
    else $error("bank exchange write-back wrong");

  AST_XCH_DIR_WB: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_XCH_DIR |=> wr_q.we && wr_q.dest == nsx_pkg::DEST_DIR
      && wr_q.addr == $past(instr_in.operand))
    else $error("direct exchange write-back wrong");

  AST_DIGIT_EXCHANGE_OP_WB: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_DIGIT_EXCHANGE_OP |=> wr_q.we && wr_q.dest == nsx_pkg::DEST_IRAM
      && wr_q.addr == $past(ptr_rd_in))
    else $error("digit exchange write-back wrong");

  AST_XRL_BANK: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_XRL_BANK |=> acc_q == (acc_p ^ $past(bank_rd_in)) && !wr_q.we)
    else $error("xor bank wrong");

  AST_XRL_A_DIR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_XRL_A_DIR |=> acc_q == (acc_p ^ $past(dir_rd_in)) && !wr_q.we)
    else $error("xor direct source wrong");

  AST_XRL_IND: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_XRL_IND |=> acc_q == (acc_p ^ $past(iram_rd_in)) && !wr_q.we)
    else $error("xor indirect wrong");

  // a ram destination must see the plain read path, not the latch
  AST_XRL_DIR_RAM: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_XRL_DIR_A && !is_sfr |=> wr_q.data == ($past(dir_rd_in) ^ acc_p)
      && acc_q == acc_p)
    else $error("xor to ram wrong");

  AST_XRL_IMM_LATCH: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_XRL_DIR_IMM && is_sfr
      |=> wr_q.data == ($past(dir_latch_in) ^ $past(instr_in.operand2)))
    else $error("port xor immediate did not use latch");

  AST_XRL_DIR_A_ACC: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_XRL_DIR_A |=> wr_q.we && acc_q == acc_p
      && wr_q.addr == $past(instr_in.operand))
    else $error("xor accumulator mask wrong");

  AST_SWAP_NO_WR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_SWAP |=> !wr_q.we && done_q)
    else $error("swap wrote an operand");

  // pulses must drop when no instruction is issued
  AST_DONE_IDLE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !start_in |=> !done_q)
    else $error("done without start");

  AST_WR_IDLE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !start_in |=> !wr_q.we)
    else $error("write without start");

  AST_ACC_HOLD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !start_in |=> acc_q == acc_p)
    else $error("accumulator moved while idle");

  // unknown opcodes are dropped rather than trapped; the decoder upstream owns that
  AST_NONE_KEEP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    start_in && op == nsx_pkg::NSX_NONE |=> acc_q == acc_p && !done_q && !wr_q.we)
    else $error("unknown opcode changed state");

  COV_SWAP: cover property (@(posedge clk_in) start_in && op == nsx_pkg::NSX_SWAP);
  COV_DIGIT_EXCHANGE_OP: cover property (@(posedge clk_in) start_in && op == nsx_pkg::NSX_DIGIT_EXCHANGE_OP);
  COV_XRL_PORT: cover property (@(posedge clk_in) start_in && op == nsx_pkg::NSX_XRL_DIR_IMM && is_sfr);
  COV_XCH_BANK: cover property (@(posedge clk_in) start_in && op == nsx_pkg::NSX_XCH_BANK);
  COV_XRL_DIR_A: cover property (@(posedge clk_in) start_in && op == nsx_pkg::NSX_XRL_DIR_A && !is_sfr);
endmodule

// [nibble_swap_exchange_xor_unit_test.sv]
// Purpose: self-checking bench for nsx_unit
// Assumes: each read port shows a distinct byte; bank_v and iram_v are changed by the exchange tests
// Notes: each op is idled one cycle after it to see the one-cycle pulses drop
`timescale 1ns/1ns
module nibble_swap_exchange_xor_unit_test;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic start_in = 1'b0;
  nsx_pkg::nsx_instr_t instr = '0;
  logic [7:0] bank_v = 8'h5a, ptr_v = 8'h20, iram_v = 8'h75, dir_v = 8'h3c, latch_v = 8'he1;
  logic [2:0] bank_sel;
  logic ptr_sel, done, flags_we;
  logic [7:0] acc, a;
  nsx_pkg::nsx_wr_t wr;
  int num_errors = 0;
  int comparisons = 0;

  nsx_unit dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .start_in(start_in), .instr_in(instr),
    .bank_rd_in(bank_v), .ptr_rd_in(ptr_v), .iram_rd_in(iram_v), .dir_rd_in(dir_v),
    .dir_latch_in(latch_v), .bank_sel_out(bank_sel), .ptr_sel_out(ptr_sel), .acc_out(acc),
    .wr_out(wr), .done_out(done), .flags_we_out(flags_we));

  initial begin
    forever #10 clk_in = ~clk_in;
  end

  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one instruction; ew is the full write-back, or zero where nothing is written
  task automatic ex(input logic [7:0] opc, opn, op2, input logic ed, input logic [7:0] ea,
                    input logic [19:0] ew);
    @(negedge clk_in);
    instr = {opc, opn, op2};
    start_in = 1'b1;
    #1 chk("bank_sel", opc[2:0], bank_sel);
    chk("ptr_sel", opc[0], ptr_sel);
    @(negedge clk_in);
    start_in = 1'b0;
    chk("done", ed, done);
    chk("acc", ea, acc);
    chk("flags_we", 1'b0, flags_we);
    chk("we", ew[19], wr.we);
    if (ew[19]) chk("wr", ew, wr);
    @(negedge clk_in);
    chk("done_end", 1'b0, done);
    chk("we_end", 1'b0, wr.we);
    a = ea;
  endtask

  task automatic t_swap;
    ex(nsx_pkg::OPC_XCH_DIR, 8'h30, 8'h00, 1'b1, dir_v, {1'b1, nsx_pkg::DEST_DIR, 8'h30, a});
    ex(nsx_pkg::OPC_SWAP, 8'h00, 8'h00, 1'b1, {a[3:0], a[7:4]}, 20'h0);
    $display("test swap finished");
  endtask

  task automatic t_xch;
    for (int i = 0; i < 8; i++) begin
      bank_v = 8'h10 + i[7:0];
      ex({nsx_pkg::OPC_XCH_BANK, i[2:0]}, 8'h0, 8'h0, 1'b1, bank_v,
         {1'b1, nsx_pkg::DEST_BANK, 5'h0, i[2:0], a});
    end
    for (int i = 0; i < 2; i++)
      ex({nsx_pkg::OPC_XCH_IND, i[0]}, 8'h0, 8'h0, 1'b1, iram_v, {1'b1, nsx_pkg::DEST_IRAM, ptr_v, a});
    $display("test exchange finished");
  endtask

  task automatic t_digit_exchange_op;
    for (int i = 0; i < 2; i++) begin
      iram_v = i ? 8'h9e : 8'h36;
      ex({nsx_pkg::OPC_DIGIT_EXCHANGE_OP_IND, i[0]}, 8'h0, 8'h0, 1'b1, {a[7:4], iram_v[3:0]},
         {1'b1, nsx_pkg::DEST_IRAM, ptr_v, iram_v[7:4], a[3:0]});
    end
    $display("test digit exchange finished");
  endtask

  task automatic t_xrl;
    for (int i = 0; i < 8; i++)
      ex({nsx_pkg::OPC_XRL_BANK, i[2:0]}, 8'h0, 8'h0, 1'b1, a ^ bank_v, 20'h0);
    ex(nsx_pkg::OPC_XRL_A_DIR, 8'h90, 8'h0, 1'b1, a ^ dir_v, 20'h0);
    for (int i = 0; i < 2; i++)
      ex({nsx_pkg::OPC_XRL_IND, i[0]}, 8'h0, 8'h0, 1'b1, a ^ iram_v, 20'h0);
    ex(nsx_pkg::OPC_XRL_A_IMM, 8'ha5, 8'h0, 1'b1, a ^ 8'ha5, 20'h0);
    ex(nsx_pkg::OPC_XRL_DIR_A, 8'h30, 8'h0, 1'b1, a, {1'b1, nsx_pkg::DEST_DIR, 8'h30, dir_v ^ a});
    ex(nsx_pkg::OPC_XRL_DIR_A, 8'h90, 8'h0, 1'b1, a, {1'b1, nsx_pkg::DEST_DIR, 8'h90, latch_v ^ a});
    ex(nsx_pkg::OPC_XRL_DIR_IMM, 8'h80, 8'h31, 1'b1, a, {1'b1, nsx_pkg::DEST_DIR, 8'h80, latch_v ^ 8'h31});
    ex(nsx_pkg::OPC_XRL_DIR_IMM, 8'h7f, 8'h31, 1'b1, a, {1'b1, nsx_pkg::DEST_DIR, 8'h7f, dir_v ^ 8'h31});
    $display("test xor finished");
  endtask

  task automatic t_bad;
    ex(8'ha5, 8'h30, 8'h0, 1'b0, a, 20'h0);
    $display("test unknown opcode finished");
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    sys_rst_in = 1'b0;
    chk("acc_rst", nsx_pkg::ACC_RST, acc);
    a = nsx_pkg::ACC_RST;
    t_swap();
    t_xch();
    t_digit_exchange_op();
    t_xrl();
    t_bad();
    results();
  end
endmodule
